/* File: src/smb_pkg.sv */
package smb_pkg;
  // -------------------------------------------------------------------------
  // clocks and bus rate
  // -------------------------------------------------------------------------
  localparam int CLK_NS     = 20;     // host clock period
  localparam int LINK_NS    = 48;     // device sampling clock period
  localparam int SCL_KHZ    = 100;    // top serial clock rate
  localparam int SCL_PER_NS = 1000000 / SCL_KHZ;
  // quarter of one serial bit, least time so round up
  localparam int QTR_CYC    = (SCL_PER_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);

  // -------------------------------------------------------------------------
  // timing limits
  // -------------------------------------------------------------------------
  localparam int STRETCH_US  = 1000;  // longest clock stretch
  localparam int STRETCH_CYC = (STRETCH_US * 1000) / LINK_NS;
  localparam int TOUT_MS     = 25;    // scl low time-out, least
  localparam int TOUT_CYC    = (TOUT_MS * 1000000 + LINK_NS - 1) / LINK_NS;
  localparam int MEMWR_MS    = 5;     // wait after a memory write
  localparam int MEMWR_CYC   = (MEMWR_MS * 1000000 + CLK_NS - 1) / CLK_NS;

  // -------------------------------------------------------------------------
  // addressing and sizes
  // -------------------------------------------------------------------------
  localparam logic [7:0] CTRL_BASE = 8'hB0;
  localparam logic [7:0] MEM_BASE  = 8'hA0;
  localparam int         STRAP_LSB = 1;    // straps sit at byte bits 3..1
  localparam int         RW_BIT    = 0;    // 1 = read
  localparam int         MEM_BYTES = 256;
  localparam int         BLOCK_MAX = 255;
endpackage : smb_pkg

/* File: src/smb_if.sv */
`timescale 1ns/10ps
interface smb_if;
  // open-drain enables of each end
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_scl_oe;
  logic dev_sda_oe;
  // resolved wire levels, pulled up when nobody drives
  logic scl;
  logic sda;

  assign scl = ~(host_scl_oe | dev_scl_oe);
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport dev_mp  (input scl, input sda, output dev_scl_oe, output dev_sda_oe);
  modport host_mp (input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface : smb_if

/* File: src/smb_dev.sv */
// Contract
// - device is slave only, never starts transfers
// - run correctly at full 100 kbps rate
// - release a stretched scl within 1 ms
// - scl low too long: abandon, go idle
// - start or stop anywhere restarts protocol state
// - address from three straps, ground is zero
// - open strap reads high via pull-up
// - controller base B0, memory A0, straps bits 3..1
// - bit 0 is direction, upper seven compared
// - two targets share bus, each own address
// - memory holds 256 user bytes, unused internally
// - host should use single-byte memory transfers
// - memory write: address, pointer, data, stop
// - host waits 5 ms after memory write
// - memory read: pointer, repeated start, read address
// - controller writes end after 0..2 bytes; 255 max
`timescale 1ns/10ps
module smb_dev #(
  parameter int STRETCH_CYC = smb_pkg::STRETCH_CYC,
  parameter int TOUT_CYC    = smb_pkg::TOUT_CYC
) (
  // user side clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // link sampling clock
  input  wire logic       link_clk,
  // serial bus
  smb_if.dev_mp           bus,
  // address straps, high when tied to ground
  input  wire logic       addr_strap_hi_gnd,
  input  wire logic       addr_strap_mid_gnd,
  input  wire logic       addr_strap_lo_gnd,
  // controller target, bytes written by the host
  output logic            ctrl_wr_valid,
  output logic            ctrl_wr_first,
  output logic [7:0]      ctrl_wr_byte,
  // controller target, bytes read by the host
  output logic            ctrl_rd_req,
  input  wire logic       ctrl_rd_valid,
  input  wire logic [7:0] ctrl_rd_byte
);
  // -------------------------------------------------------------------------
  // checks and types
  // -------------------------------------------------------------------------
  if (STRETCH_CYC < 2 || STRETCH_CYC >= 2 ** 15) begin : g_chk_str
    $error("stretch count out of range");
  end
  if (TOUT_CYC < 2 || TOUT_CYC >= 2 ** 20) begin : g_chk_tout
    $error("time-out count out of range");
  end

  typedef enum logic [2:0] {L_IDLE, L_RX, L_TX, L_TXN, L_WAIT, L_IGN} smb_lst_t;

  typedef struct packed {
    logic                         scl_m, scl_s, scl_p;
    logic                         sda_m, sda_s, sda_p;
    logic [2:0]                   strap_m, strap_s;
    logic                         ak_m, ak_s, ak_p;
    smb_lst_t                     st;
    logic [3:0]                   bitn;
    logic [7:0]                   sh;
    logic                         ack_ph;
    logic                         first;
    logic                         tgt_mem;
    logic                         rd;
    logic [8:0]                   idx;
    logic [7:0]                   ptr;
    logic [smb_pkg::MEM_BYTES-1:0][7:0] mem;
    logic                         scl_oe;
    logic                         sda_oe;
    logic [19:0]                  lowcnt;
    logic [14:0]                  strcnt;
    logic                         wr_tgl;
    logic                         wr_first;
    logic [7:0]                   wr_byte;
    logic                         rq_tgl;
  } smb_lnk_t;

  typedef struct packed {
    logic       wt_m, wt_s, wt_p;
    logic       rq_m, rq_s, rq_p;
    logic       wr_valid;
    logic       wr_first;
    logic [7:0] wr_byte;
    logic       rd_req;
    logic       ak_tgl;
    logic [7:0] rd_hold;
  } smb_usr_t;

  smb_lnk_t r_r, r_nxt;
  smb_usr_t c_r, c_nxt;

  // address byte matches a base with the strapped bits
  function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] base,
                                    input logic [2:0] strap);
    addr_hit = (b[7:4] == base[7:4]) &&
               (b[smb_pkg::STRAP_LSB +: 3] == strap);
  endfunction : addr_hit

  // -------------------------------------------------------------------------
  // link domain
  // -------------------------------------------------------------------------
  logic       rise, fall, cond_start, cond_stop, ack;
  logic [2:0] strap;
  logic [7:0] ld;

  // protocol engine: lines are oversampled, so edges show a few cycles late
  always_comb
  begin
    r_nxt         = r_r;
    r_nxt.scl_m   = bus.scl;
    r_nxt.scl_s   = r_r.scl_m;
    r_nxt.scl_p   = r_r.scl_s;
    r_nxt.sda_m   = bus.sda;
    r_nxt.sda_s   = r_r.sda_m;
    r_nxt.sda_p   = r_r.sda_s;
    r_nxt.strap_m = {addr_strap_hi_gnd, addr_strap_mid_gnd, addr_strap_lo_gnd};
    r_nxt.strap_s = r_r.strap_m;
    r_nxt.ak_m    = c_r.ak_tgl;
    r_nxt.ak_s    = r_r.ak_m;
    r_nxt.ak_p    = r_r.ak_s;
    strap         = ~r_r.strap_s;
    rise          = r_r.scl_s & ~r_r.scl_p;
    fall          = ~r_r.scl_s & r_r.scl_p;
    cond_start    = r_r.scl_s & r_r.scl_p & r_r.sda_p & ~r_r.sda_s;
    cond_stop     = r_r.scl_s & r_r.scl_p & ~r_r.sda_p & r_r.sda_s;
    ack           = 1'b0;
    ld            = 8'hFF;
    // scl low counter, frozen at the limit
    if (r_r.scl_s)
      r_nxt.lowcnt = '0;
    else if (r_r.lowcnt != 20'(TOUT_CYC))
      r_nxt.lowcnt = r_r.lowcnt + 20'h00001;

    if (r_r.lowcnt == 20'(TOUT_CYC - 1))
    begin
      r_nxt.st     = L_IDLE;
      r_nxt.scl_oe = 1'b0;
      r_nxt.sda_oe = 1'b0;
    end
    else if (cond_start)
    begin
      r_nxt.st     = L_RX;
      r_nxt.bitn   = '0;
      r_nxt.first  = 1'b1;
      r_nxt.ack_ph = 1'b0;
      r_nxt.scl_oe = 1'b0;
      r_nxt.sda_oe = 1'b0;
    end
    else if (cond_stop)
    begin
      r_nxt.st     = L_IDLE;
      r_nxt.sda_oe = 1'b0;
    end
    else
    begin
      unique case (r_r.st)
        L_RX:
        begin
          if (rise && r_r.bitn < 4'h8)
          begin
            r_nxt.sh   = {r_r.sh[6:0], r_r.sda_s};
            r_nxt.bitn = r_r.bitn + 4'h1;
          end
          if (fall && r_r.ack_ph)
          begin
            // ack slot over: release sda, carry on
            r_nxt.ack_ph = 1'b0;
            r_nxt.sda_oe = 1'b0;
            r_nxt.bitn   = '0;
            if (r_r.rd)
            begin
              if (r_r.tgt_mem)
              begin
                ld           = r_r.mem[r_r.ptr];
                r_nxt.ptr    = r_r.ptr + 8'h01;
                r_nxt.sh     = ld;
                r_nxt.sda_oe = ~ld[7];
                r_nxt.bitn   = 4'h1;
                r_nxt.st     = L_TX;
              end
              else
              begin
                r_nxt.scl_oe = 1'b1;
                r_nxt.strcnt = '0;
                r_nxt.rq_tgl = ~r_r.rq_tgl;
                r_nxt.st     = L_WAIT;
              end
            end
          end
          else if (fall && r_r.bitn == 4'h8)
          begin
            if (r_r.first)
            begin
              // two targets, one bus: claim only our own addresses
              if (addr_hit(r_r.sh, smb_pkg::CTRL_BASE, strap))
              begin
                ack           = 1'b1;
                r_nxt.tgt_mem = 1'b0;
              end
              else if (addr_hit(r_r.sh, smb_pkg::MEM_BASE, strap))
              begin
                ack           = 1'b1;
                r_nxt.tgt_mem = 1'b1;
              end
              r_nxt.rd    = r_r.sh[smb_pkg::RW_BIT];
              r_nxt.first = 1'b0;
              r_nxt.idx   = '0;
            end
            else
            begin
              ack       = (r_r.idx <= 9'(smb_pkg::BLOCK_MAX));
              r_nxt.idx = (r_r.idx == 9'h1FF) ? r_r.idx : r_r.idx + 9'h001;
              if (ack && r_r.tgt_mem)
              begin
                if (r_r.idx == 9'h000)
                  r_nxt.ptr = r_r.sh;
                else
                begin
                  r_nxt.mem[r_r.ptr] = r_r.sh;
                  r_nxt.ptr          = r_r.ptr + 8'h01;
                end
              end
              else if (ack)
              begin
                r_nxt.wr_tgl   = ~r_r.wr_tgl;
                r_nxt.wr_byte  = r_r.sh;
                r_nxt.wr_first = (r_r.idx == 9'h000);
              end
            end
            // sda only ever pulled in ack and read data slots
            r_nxt.ack_ph = ack;
            r_nxt.sda_oe = ack;
            if (!ack)
              r_nxt.st = L_IGN;
          end
        end
        L_TX:
        begin
          if (fall && r_r.bitn < 4'h8)
          begin
            r_nxt.sh     = {r_r.sh[6:0], 1'b0};
            r_nxt.sda_oe = ~r_r.sh[6];
            r_nxt.bitn   = r_r.bitn + 4'h1;
          end
          else if (fall && r_r.bitn == 4'h8)
          begin
            r_nxt.sda_oe = 1'b0;
            r_nxt.bitn   = 4'h9;
          end
          if (rise && r_r.bitn == 4'h9)
            r_nxt.st = r_r.sda_s ? L_IGN : L_TXN;
        end
        L_TXN:
        begin
          if (fall && r_r.tgt_mem)
          begin
            ld           = r_r.mem[r_r.ptr];
            r_nxt.ptr    = r_r.ptr + 8'h01;
            r_nxt.sh     = ld;
            r_nxt.sda_oe = ~ld[7];
            r_nxt.bitn   = 4'h1;
            r_nxt.st     = L_TX;
          end
          else if (fall)
          begin
            r_nxt.scl_oe = 1'b1;
            r_nxt.strcnt = '0;
            r_nxt.rq_tgl = ~r_r.rq_tgl;
            r_nxt.st     = L_WAIT;
          end
        end
        L_WAIT:
        begin
          // a late answer is dropped: 0xFF goes out when the stretch limit hits
          r_nxt.strcnt = r_r.strcnt + 15'h0001;
          if ((r_r.ak_s ^ r_r.ak_p) || r_r.strcnt == 15'(STRETCH_CYC - 1))
          begin
            ld           = (r_r.ak_s ^ r_r.ak_p) ? c_r.rd_hold : 8'hFF;
            r_nxt.sh     = ld;
            r_nxt.sda_oe = ~ld[7];
            r_nxt.scl_oe = 1'b0;
            r_nxt.bitn   = 4'h1;
            r_nxt.st     = L_TX;
          end
        end
        L_IDLE, L_IGN:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  // -------------------------------------------------------------------------
  // user domain: toggles in, toggle out with held byte
  // -------------------------------------------------------------------------
  always_comb
  begin
    c_nxt          = c_r;
    c_nxt.wt_m     = r_r.wr_tgl;
    c_nxt.wt_s     = c_r.wt_m;
    c_nxt.wt_p     = c_r.wt_s;
    c_nxt.rq_m     = r_r.rq_tgl;
    c_nxt.rq_s     = c_r.rq_m;
    c_nxt.rq_p     = c_r.rq_s;
    c_nxt.wr_valid = c_r.wt_s ^ c_r.wt_p;
    c_nxt.rd_req   = c_r.rq_s ^ c_r.rq_p;
    // link byte is stable for many link cycles after its toggle
    if (c_r.wt_s ^ c_r.wt_p)
    begin
      c_nxt.wr_byte  = r_r.wr_byte;
      c_nxt.wr_first = r_r.wr_first;
    end
    if (ctrl_rd_valid)
    begin
      c_nxt.rd_hold = ctrl_rd_byte;
      c_nxt.ak_tgl  = ~c_r.ak_tgl;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      c_r <= '0;
    else
      c_r <= c_nxt;
  end

  // outputs
  assign bus.dev_scl_oe = r_r.scl_oe;
  assign bus.dev_sda_oe = r_r.sda_oe;
  assign ctrl_wr_valid  = c_r.wr_valid;
  assign ctrl_wr_first  = c_r.wr_first;
  assign ctrl_wr_byte   = c_r.wr_byte;
  assign ctrl_rd_req    = c_r.rd_req;
endmodule : smb_dev

/* File: src/smb_host.sv */
`timescale 1ns/10ps
module smb_host #(
  parameter int QTR_CYC   = smb_pkg::QTR_CYC,
  parameter int MEMWR_CYC = smb_pkg::MEMWR_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // serial bus
  smb_if.host_mp           bus,
  // command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_read,
  input  wire logic        cmd_mem,
  input  wire logic [2:0]  cmd_strap,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic [1:0]  cmd_wlen,
  // answer
  output logic             rsp_done,
  output logic             rsp_nack,
  output logic [7:0]       rsp_rdata
);
  // -------------------------------------------------------------------------
  // checks and types
  // -------------------------------------------------------------------------
  if (QTR_CYC < 2 || QTR_CYC >= 2 ** 8) begin : g_chk_qtr
    $error("quarter count out of range");
  end
  if (MEMWR_CYC < 2 * QTR_CYC || MEMWR_CYC >= 2 ** 18) begin : g_chk_mw
    $error("memory write wait out of range");
  end

  typedef enum logic [3:0] {
    H_IDLE, H_ST1, H_ST2, H_BIT, H_RS1, H_RS2, H_P1, H_P2, H_P3, H_GAP
  } smb_hst_t;

  typedef struct packed {
    logic        scl_m, scl_s, sda_m, sda_s;
    smb_hst_t    st;
    logic [7:0]  qcnt;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [2:0]  step;
    logic        rd, mem;
    logic [7:0]  adr, code;
    logic [15:0] wdata;
    logic [1:0]  wlen;
    logic [17:0] gap;
    logic        scl_oe, sda_oe;
    logic        done, nack;
    logic [7:0]  rdata;
  } smb_hreg_t;

  smb_hreg_t r_r, r_nxt;

  // byte sent at each step; reading sends all ones, i.e. releases sda
  function automatic logic [7:0] step_byte(input smb_hreg_t s, input logic [2:0] k);
    unique case (k)
      3'h0:    step_byte = s.adr;
      3'h1:    step_byte = s.code;
      3'h2:    step_byte = s.wdata[7:0];
      3'h3:    step_byte = s.wdata[15:8];
      3'h4:    step_byte = s.adr | 8'h01;
      default: step_byte = 8'hFF;
    endcase
  endfunction : step_byte

  logic tick, cdone;

  // -------------------------------------------------------------------------
  // bus master sequencer
  // -------------------------------------------------------------------------
  always_comb
  begin
    r_nxt       = r_r;
    r_nxt.scl_m = bus.scl;
    r_nxt.scl_s = r_r.scl_m;
    r_nxt.sda_m = bus.sda;
    r_nxt.sda_s = r_r.sda_m;
    r_nxt.done  = 1'b0;
    // a released scl held low by the slave keeps the quarter timer at zero
    tick        = (r_r.qcnt == 8'(QTR_CYC - 1));
    if ((!r_r.scl_oe && !r_r.scl_s) || r_r.st == H_IDLE || tick)
      r_nxt.qcnt = '0;
    else
      r_nxt.qcnt = r_r.qcnt + 8'h01;
    if (tick && r_r.st != H_BIT)
      r_nxt.ph = {1'b0, ~r_r.ph[0]};
    cdone = tick && r_r.ph[0];
    unique case (r_r.st)
      H_IDLE:
      begin
        if (cmd_valid)
        begin
          r_nxt.rd    = cmd_read;
          r_nxt.mem   = cmd_mem;
          r_nxt.adr   = (cmd_mem ? smb_pkg::MEM_BASE : smb_pkg::CTRL_BASE) |
                        {4'h0, cmd_strap, 1'b0};
          r_nxt.code  = cmd_code;
          r_nxt.wdata = cmd_wdata;
          r_nxt.wlen  = (cmd_mem && cmd_wlen != 2'h0) ? 2'h1 : cmd_wlen;
          r_nxt.step  = '0;
          r_nxt.nack  = 1'b0;
          r_nxt.ph    = '0;
          r_nxt.st    = H_ST1;
        end
      end
      H_ST1:
      begin
        if (cdone)
        begin
          r_nxt.sda_oe = 1'b1;
          r_nxt.st     = H_ST2;
        end
      end
      H_ST2:
      begin
        if (cdone)
        begin
          r_nxt.scl_oe = 1'b1;
          r_nxt.sh     = step_byte(r_r, r_r.step);
          r_nxt.bitn   = '0;
          r_nxt.ph     = '0;
          r_nxt.st     = H_BIT;
        end
      end
      H_BIT:
      begin
        if (tick)
        begin
          r_nxt.ph = r_r.ph + 2'h1;
          unique case (r_r.ph)
            2'h0: r_nxt.sda_oe = (r_r.bitn < 4'h8) & ~r_r.sh[7];
            2'h1: r_nxt.scl_oe = 1'b0;
            2'h2:
            begin
              if (r_r.bitn < 4'h8)
                r_nxt.sh = {r_r.sh[6:0], r_r.sda_s};
              else if (r_r.step != 3'h5)
                r_nxt.nack = r_r.sda_s;
            end
            2'h3:
            begin
              r_nxt.scl_oe = 1'b1;
              r_nxt.bitn   = r_r.bitn + 4'h1;
              if (r_r.bitn == 4'h8)
              begin
                r_nxt.bitn = '0;
                r_nxt.st   = H_P1;
                if (r_r.step == 3'h5)
                  r_nxt.rdata = r_r.sh;
                else if (!r_r.nack)
                begin
                  if (r_r.step == 3'h1 && r_r.rd)
                    r_nxt.st = H_RS1;
                  else if (r_r.step == 3'h0 || r_r.step == 3'h4 ||
                           (r_r.step == 3'h1 && r_r.wlen != 2'h0) ||
                           (r_r.step == 3'h2 && r_r.wlen == 2'h2))
                  begin
                    r_nxt.step = r_r.step + 3'h1;
                    r_nxt.sh   = step_byte(r_r, r_r.step + 3'h1);
                    r_nxt.st   = H_BIT;
                  end
                end
              end
            end
          endcase
        end
      end
      H_RS1:
      begin
        if (cdone)
        begin
          r_nxt.sda_oe = 1'b0;
          r_nxt.st     = H_RS2;
        end
      end
      H_RS2:
      begin
        if (cdone)
        begin
          r_nxt.scl_oe = 1'b0;
          r_nxt.step   = 3'h4;
          r_nxt.st     = H_ST1;
        end
      end
      H_P1:
      begin
        if (cdone)
        begin
          r_nxt.sda_oe = 1'b1;
          r_nxt.st     = H_P2;
        end
      end
      H_P2:
      begin
        if (cdone)
        begin
          r_nxt.scl_oe = 1'b0;
          r_nxt.st     = H_P3;
        end
      end
      H_P3:
      begin
        if (cdone)
        begin
          // a memory write needs its programming time before the next start
          r_nxt.sda_oe = 1'b0;
          r_nxt.done   = 1'b1;
          r_nxt.gap    = (r_r.mem && !r_r.rd) ? 18'(MEMWR_CYC) :
                                                18'(2 * QTR_CYC);
          r_nxt.st     = H_GAP;
        end
      end
      H_GAP:
      begin
        r_nxt.gap = r_r.gap - 18'h00001;
        if (r_r.gap == 18'h00001)
          r_nxt.st = H_IDLE;
      end
      default: r_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  // outputs
  assign bus.host_scl_oe = r_r.scl_oe;
  assign bus.host_sda_oe = r_r.sda_oe;
  assign cmd_ready       = (r_r.st == H_IDLE);
  assign rsp_done        = r_r.done;
  assign rsp_nack        = r_r.nack;
  assign rsp_rdata       = r_r.rdata;
endmodule : smb_host

/* File: dv/smb_chk_sva.sv */
`timescale 1ns/10ps
module smb_chk #(
  parameter int QTR_CYC     = 50,
  parameter int STRETCH_CYC = 200,
  parameter int TOUT_CYC    = 2000
) (
  // clocks and reset
  input wire logic clk,
  input wire logic link_clk,
  input wire logic rst_b,
  // bus wires and device enables
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe
);
  // a level must last two quarters; two samples of slack for the edges
  localparam int HALF    = 2 * QTR_CYC - 2;
  localparam int STR_LIM = STRETCH_CYC + 16;
  localparam int TOUT_LIM = TOUT_CYC + 16;
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic [15:0] run_cnt;
  logic [15:0] lo_lnk;
  logic [4:0]  bit_cnt;
  logic        scl_q;
  logic        lscl_q;
  logic        lsda_q;
  // length of the present scl level in host cycles
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      scl_q   <= 1'b1;
      run_cnt <= 16'h0000;
    end
    else
    begin
      scl_q   <= scl;
      run_cnt <= (scl != scl_q) ? 16'h0001 : run_cnt + {15'h0000, run_cnt != 16'hFFFF};
    end
  // rises since the last start, and scl low time, seen at the link
  always_ff @(posedge link_clk or negedge rst_b)
    if (!rst_b)
    begin
      lscl_q  <= 1'b1;
      lsda_q  <= 1'b1;
      bit_cnt <= 5'h00;
      lo_lnk  <= 16'h0000;
    end
    else
    begin
      lscl_q <= scl;
      lsda_q <= sda;
      if (scl && lscl_q && lsda_q && !sda)
        bit_cnt <= 5'h00;
      else if (scl && !lscl_q && bit_cnt != 5'h1F)
        bit_cnt <= bit_cnt + 5'h01;
      lo_lnk <= scl ? 16'h0000 : lo_lnk + {15'h0000, lo_lnk != 16'(TOUT_LIM)};
    end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  no_dev_start_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    $rose(dev_sda_oe) |-> !scl) else $error("device pulled sda with scl high");
  no_dev_stop_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    $fell(dev_sda_oe) |-> !scl) else $error("device freed sda with scl high");
  hold_low_only_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    $rose(dev_scl_oe) |-> !scl) else $error("device pulled scl while high");
  stretch_bound_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    $rose(dev_scl_oe) |-> ##[1:STR_LIM] !dev_scl_oe) else $error("stretch too long");
  tout_release_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    lo_lnk == 16'(TOUT_LIM) |-> !dev_scl_oe && !dev_sda_oe) else $error("no time-out");
  addr_quiet_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    bit_cnt < 5'h08 |-> !dev_sda_oe) else $error("device drove sda in address");
  scl_high_min_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(scl) |-> run_cnt >= 16'(HALF)) else $error("scl high too short");
  scl_low_min_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(scl) |-> run_cnt >= 16'(HALF)) else $error("scl low too short");
  // main scenarios reached
  cover property (@(posedge link_clk) disable iff (!rst_b) $rose(dev_scl_oe));
  cover property (@(posedge link_clk) disable iff (!rst_b) $rose(dev_sda_oe));
  cover property (@(posedge link_clk) disable iff (!rst_b) bit_cnt == 5'h11);
endmodule : smb_chk

/* File: dv/smbus_slave_dual_address_test.sv */
`timescale 1ns/10ps
module smbus_slave_dual_address_test;
  logic        clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, answer = 1'b1;
  logic        cmd_valid = 1'b0, cmd_read = 1'b0, cmd_mem = 1'b0, rd_vld = 1'b0;
  logic [2:0]  cmd_strap = 3'h0, gnd = 3'h2;  // straps read 101
  logic [7:0]  cmd_code = 8'h00, rd_byte = 8'h96, rsp_rdata, wr_byte;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [1:0]  cmd_wlen = 2'h0;
  logic        cmd_ready, rsp_done, rsp_nack, wr_vld, wr_first, rd_req;
  logic [8:0]  wr_q[$];
  int          num_errors = 0, total_checks = 0;
  always #10 clk = ~clk;
  initial
  begin
    #3;
    forever
    begin
      link_clk = ~link_clk;
      #24;
    end
  end
  smb_if bus ();
  smb_host #(.QTR_CYC(50), .MEMWR_CYC(600)) u_smb_host (.clk(clk), .rst_b(rst_b), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_mem(cmd_mem),
    .cmd_strap(cmd_strap), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_wlen(cmd_wlen),
    .rsp_done(rsp_done), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));
  smb_dev #(.STRETCH_CYC(200), .TOUT_CYC(2000)) u_smb_dev (.clk(clk), .rst_b(rst_b),
    .link_clk(link_clk), .bus(bus), .addr_strap_hi_gnd(gnd[2]), .addr_strap_mid_gnd(gnd[1]),
    .addr_strap_lo_gnd(gnd[0]), .ctrl_wr_valid(wr_vld), .ctrl_wr_first(wr_first),
    .ctrl_wr_byte(wr_byte), .ctrl_rd_req(rd_req), .ctrl_rd_valid(rd_vld),
    .ctrl_rd_byte(rd_byte));
  // checker defaults already match the bench's scaled timing
  smb_chk u_smb_chk (.clk(clk),
    .link_clk(link_clk), .rst_b(rst_b), .scl(bus.scl), .sda(bus.sda),
    .dev_scl_oe(bus.dev_scl_oe), .dev_sda_oe(bus.dev_sda_oe));
  // controller user side: answer one cycle after a request, log writes
  always @(posedge clk)
  begin
    rd_vld <= rd_req & answer;
    if (wr_vld) wr_q.push_back({wr_first, wr_byte});
  end
  task automatic check(string what, logic [8:0] exp, logic [8:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // one host transfer; a hang counts as a mismatch and ends the run
  task automatic xfer(logic rd, mem, logic [2:0] st, logic [7:0] cd, logic [15:0] wd,
                      logic [1:0] wl, logic nk, logic [7:0] exp);
    int n;
    n = 0;
    do @(negedge clk) n++; while (cmd_ready !== 1'b1 && n < 40000);
    @(posedge clk);
    {cmd_read, cmd_mem, cmd_strap, cmd_code, cmd_wdata, cmd_wlen} <= {rd, mem, st, cd, wd, wl};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do @(negedge clk) n++; while (rsp_done !== 1'b1 && n < 40000);
    if (n >= 40000)
    begin
      num_errors++;
      give_verdict();
    end
    else
    begin
      check("nack", {8'h00, nk}, {8'h00, rsp_nack});
      if (rd && !nk) check("rdata", {1'b0, exp}, {1'b0, rsp_rdata});
    end
  endtask : xfer
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    // memory bytes stored and read back, top location too
    xfer(0, 1, 3'h5, 8'h5A, 16'h00C3, 2'h1, 0, 8'h00);
    xfer(0, 1, 3'h5, 8'hFF, 16'h003C, 2'h1, 0, 8'h00);
    xfer(1, 1, 3'h5, 8'h5A, 16'h0000, 2'h0, 0, 8'hC3);
    xfer(1, 1, 3'h5, 8'hFF, 16'h0000, 2'h0, 0, 8'h3C);
    // controller writes ending after zero, one and two data bytes
    for (int w = 0; w < 3; w++)
    begin
      xfer(0, 0, 3'h5, 8'h21, 16'hBEEF, 2'(w), 0, 8'h00);
      check("first", 9'h121, wr_q.pop_front());
      if (w > 0) check("low", 9'h0EF, wr_q.pop_front());
      if (w > 1) check("high", 9'h0BE, wr_q.pop_front());
      check("count", 9'h000, 9'(wr_q.size()));
    end
    // controller read answered, then left to run out its stretch
    xfer(1, 0, 3'h5, 8'h33, 16'h0000, 2'h0, 0, 8'h96);
    check("command", 9'h133, wr_q.pop_front());
    answer = 1'b0;
    xfer(1, 0, 3'h5, 8'h33, 16'h0000, 2'h0, 0, 8'hFF);
    check("command", 9'h133, wr_q.pop_front());
    // foreign addresses refused; the next start is served again
    xfer(0, 1, 3'h4, 8'h5A, 16'h0011, 2'h1, 1, 8'h00);
    xfer(1, 0, 3'h7, 8'h33, 16'h0000, 2'h0, 1, 8'h00);
    xfer(1, 1, 3'h5, 8'h5A, 16'h0000, 2'h0, 0, 8'hC3);
    // open straps all read as one
    @(posedge clk);
    gnd <= 3'h0;
    xfer(1, 1, 3'h7, 8'h5A, 16'h0000, 2'h0, 0, 8'hC3);
    xfer(1, 1, 3'h5, 8'h5A, 16'h0000, 2'h0, 1, 8'h00);
    give_verdict();
  end
endmodule : smbus_slave_dual_address_test
